// *** hdl/otg_regbank.sv ***
// file: byte-wide register bank of the dual-role transceiver
`timescale 1ns/1ps

// How it works
// RULE_01 - reset clears every register bit except the bits whose reset constant is set.
// RULE_02 - every pin register reads zero in its five upper bits, only the low three hold pin state.
// RULE_03 - unnamed bits and unmapped addresses carry no defined meaning; this bank reads unmapped addresses as zero, keeps unnamed bits as written.
// RULE_04 - vendor and product codes are fixed constants that neither reset nor software can change.
// RULE_05 - a one written at a set address sets that bit, a one at a clear address clears it, zeros do nothing.
// RULE_06 - both addresses of a set and clear pair read back the same current contents.
// RULE_07 - the vendor code is read low byte at 00h and high byte at 01h, the product code likewise from 02h.
// RULE_08 - there is no internal power-on reset; the system reset returns all control bits to their defaults.
// RULE_09 - writes to read-only or undefined addresses are accepted and change nothing.
module otg_regbank #(
	parameter logic [15:0] VENDOR_CODE  = 16'hA5C3,  // arbitrary value
	parameter logic [15:0] PRODUCT_CODE = 16'h3C5A   // arbitrary value
) (
	input  wire logic                           clk,
	input  wire logic                           rst,
	input  wire otg_pkg::otg_req_s              req,
	output otg_pkg::otg_rsp_s                   rsp,
	input  wire logic [otg_pkg::DATA_W-1:0]     event_source,
	input  wire logic [otg_pkg::GPIO_W-1:0]     gpio_in,
	output logic      [otg_pkg::GPIO_W-1:0]     gpio_out,
	output logic      [otg_pkg::GPIO_W-1:0]     gpio_oe,
	output logic      [otg_pkg::DATA_W-1:0]     control_one,
	output logic      [otg_pkg::DATA_W-1:0]     control_two,
	output logic      [otg_pkg::DATA_W-1:0]     control_three,
	output logic                                irq
);
	import otg_pkg::*;

	// next value of a set/clear register byte
	function automatic logic [DATA_W-1:0] set_clear(
		input logic [DATA_W-1:0] cur,
		input logic [DATA_W-1:0] wdata,
		input logic              set_hit,
		input logic              clear_hit
	);
		logic [DATA_W-1:0] r;
		r = cur;
		if (set_hit)
			r = r | wdata;  // RULE_05
		if (clear_hit)
			r = r & ~wdata;  // RULE_05
		return r;
	endfunction : set_clear

	// write strobe for one address
	function automatic logic wr_hit(
		input otg_req_s          q,
		input logic [ADDR_W-1:0] a
	);
		return q.wr && (q.addr == a);
	endfunction : wr_hit

	// next value of a set/clear pin register; only the low bits hold pin state
	function automatic logic [GPIO_W-1:0] pin_set_clear(
		input logic [GPIO_W-1:0] cur,
		input logic [DATA_W-1:0] wdata,
		input logic              set_hit,
		input logic              clear_hit
	);
		logic [DATA_W-1:0] r;
		r = set_clear({{(DATA_W-GPIO_W){1'b0}}, cur}, wdata, set_hit, clear_hit);
		return r[GPIO_W-1:0];  // RULE_02
	endfunction : pin_set_clear

	// read value of a pin register, upper bits forced to zero
	function automatic logic [DATA_W-1:0] pad_pin(
		input logic [GPIO_W-1:0] v
	);
		return {{(DATA_W-GPIO_W){1'b0}}, v};  // RULE_02
	endfunction : pad_pin

	// registered state
	logic [DATA_W-1:0] int_latch;
	logic [DATA_W-1:0] fall_mask;
	logic [DATA_W-1:0] rise_mask;
	logic [DATA_W-1:0] source_prev;
	logic [GPIO_W-1:0] pin_drive;
	logic [GPIO_W-1:0] pin_level;
	logic [GPIO_W-1:0] pin_prev;
	logic [GPIO_W-1:0] pin_event;
	logic [GPIO_W-1:0] pin_fall_mask;
	logic [GPIO_W-1:0] pin_rise_mask;

	// combinational values
	logic [DATA_W-1:0] src_edge;
	logic [GPIO_W-1:0] pin_edge;
	logic [DATA_W-1:0] next_int_latch;
	logic [GPIO_W-1:0] next_pin_event;
	logic [GPIO_W-1:0] next_pin_drive;
	logic [GPIO_W-1:0] next_gpio_out;
	logic [DATA_W-1:0] next_rdata;
	logic [DATA_W-1:0] next_control_one;
	logic [DATA_W-1:0] next_control_two;
	logic [DATA_W-1:0] next_control_three;
	logic [DATA_W-1:0] next_fall_mask;
	logic [DATA_W-1:0] next_rise_mask;
	logic [GPIO_W-1:0] next_pin_fall_mask;
	logic [GPIO_W-1:0] next_pin_rise_mask;

	// masked edges of the status sources
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi++)
		begin : g_src_edge
			assign src_edge[gi] = (rise_mask[gi] & event_source[gi] & ~source_prev[gi])
				| (fall_mask[gi] & ~event_source[gi] & source_prev[gi]);
		end
		for (gi = 0; gi < GPIO_W; gi++)
		begin : g_pin_edge
			assign pin_edge[gi] = (pin_rise_mask[gi] & pin_level[gi] & ~pin_prev[gi])
				| (pin_fall_mask[gi] & ~pin_level[gi] & pin_prev[gi]);
		end
	endgenerate

	// edge history; pins are taken as synchronous
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			source_prev <= READ_ZERO;
		else
			source_prev <= event_source;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin_level <= RST_PIN_REG;
		else
			pin_level <= gpio_in;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin_prev <= RST_PIN_REG;
		else
			pin_prev <= pin_level;
	end

	// next values of the control and mask registers
	always_comb
	begin
		next_control_one   = set_clear(control_one, req.wdata, wr_hit(req, ADDR_CONTROL_ONE_SET),
			wr_hit(req, ADDR_CONTROL_ONE_CLEAR));  // RULE_05
		next_control_two   = set_clear(control_two, req.wdata, wr_hit(req, ADDR_CONTROL_TWO_SET),
			wr_hit(req, ADDR_CONTROL_TWO_CLEAR));  // RULE_05
		next_control_three = set_clear(control_three, req.wdata, wr_hit(req, ADDR_CONTROL_THREE_SET),
			wr_hit(req, ADDR_CONTROL_THREE_CLEAR));  // RULE_05
		next_fall_mask     = set_clear(fall_mask, req.wdata, wr_hit(req, ADDR_FALL_MASK_SET),
			wr_hit(req, ADDR_FALL_MASK_CLEAR));  // RULE_05
		next_rise_mask     = set_clear(rise_mask, req.wdata, wr_hit(req, ADDR_RISE_MASK_SET),
			wr_hit(req, ADDR_RISE_MASK_CLEAR));  // RULE_05
	end

	// event latches: a captured edge wins over a clear in the same cycle
	always_comb
	begin
		next_int_latch = set_clear(int_latch, req.wdata, wr_hit(req, ADDR_INT_LATCH_SET),
			wr_hit(req, ADDR_INT_LATCH_CLEAR)) | src_edge;  // RULE_05
		next_pin_event = pin_set_clear(pin_event, req.wdata, wr_hit(req, ADDR_PIN_EVENT_SET),
			wr_hit(req, ADDR_PIN_EVENT_CLEAR)) | pin_edge;  // RULE_02 RULE_05
	end

	// pin direction, output value and pin masks
	always_comb
	begin
		next_pin_drive     = pin_set_clear(pin_drive, req.wdata, wr_hit(req, ADDR_PIN_DRIVE_SET),
			wr_hit(req, ADDR_PIN_DRIVE_CLEAR));  // RULE_05
		next_gpio_out      = pin_set_clear(gpio_out, req.wdata, wr_hit(req, ADDR_PIN_OUTPUT_SET),
			wr_hit(req, ADDR_PIN_OUTPUT_CLEAR));  // RULE_05
		next_pin_fall_mask = pin_set_clear(pin_fall_mask, req.wdata, wr_hit(req, ADDR_PIN_FALL_SET),
			wr_hit(req, ADDR_PIN_FALL_CLEAR));  // RULE_05
		next_pin_rise_mask = pin_set_clear(pin_rise_mask, req.wdata, wr_hit(req, ADDR_PIN_RISE_SET),
			wr_hit(req, ADDR_PIN_RISE_CLEAR));  // RULE_05
	end

	// control registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			control_one <= RST_CONTROL_ONE;  // RULE_01 RULE_08
		else
			control_one <= next_control_one;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			control_two <= RST_CONTROL_TWO;  // RULE_01 RULE_08
		else
			control_two <= next_control_two;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			control_three <= RST_CONTROL_THREE;  // RULE_01 RULE_08
		else
			control_three <= next_control_three;
	end

	// status masks
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			fall_mask <= RST_FALL_MASK;  // RULE_01
		else
			fall_mask <= next_fall_mask;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rise_mask <= RST_RISE_MASK;  // RULE_01
		else
			rise_mask <= next_rise_mask;
	end

	// event latches
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			int_latch <= RST_INT_LATCH;  // RULE_01
		else
			int_latch <= next_int_latch;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin_event <= RST_PIN_REG;  // RULE_01
		else
			pin_event <= next_pin_event;
	end

	// pin registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin_drive <= RST_PIN_REG;  // RULE_01
		else
			pin_drive <= next_pin_drive;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			gpio_out <= RST_PIN_REG;  // RULE_01
		else
			gpio_out <= next_gpio_out;
	end

	// open drain: the pin is pulled only while enabled and low
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			gpio_oe <= RST_PIN_REG;  // RULE_01
		else
			gpio_oe <= next_pin_drive & ~next_gpio_out;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin_fall_mask <= RST_PIN_REG;  // RULE_01
		else
			pin_fall_mask <= next_pin_fall_mask;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin_rise_mask <= RST_PIN_REG;  // RULE_01
		else
			pin_rise_mask <= next_pin_rise_mask;
	end

	// interrupt condition present while any latch bit stands
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= (|next_int_latch) | (|next_pin_event);
	end

	// read multiplexer; writes elsewhere fall through untouched
	always_comb
	begin
		next_rdata = READ_ZERO;  // RULE_03 RULE_09
		case (req.addr)
			// identification bytes, low byte first
			ADDR_VENDOR_LOW:          next_rdata = VENDOR_CODE[DATA_W-1:0];  // RULE_04 RULE_07
			ADDR_VENDOR_HIGH:         next_rdata = VENDOR_CODE[2*DATA_W-1:DATA_W];  // RULE_04 RULE_07
			ADDR_PRODUCT_LOW:         next_rdata = PRODUCT_CODE[DATA_W-1:0];  // RULE_04 RULE_07
			ADDR_PRODUCT_HIGH:        next_rdata = PRODUCT_CODE[2*DATA_W-1:DATA_W];  // RULE_04 RULE_07
			ADDR_CONTROL_ONE_SET,
			ADDR_CONTROL_ONE_CLEAR:   next_rdata = control_one;  // RULE_06
			ADDR_CONTROL_TWO_SET,
			ADDR_CONTROL_TWO_CLEAR:   next_rdata = control_two;  // RULE_06
			ADDR_INT_SOURCE:          next_rdata = event_source;
			ADDR_INT_LATCH_SET,
			ADDR_INT_LATCH_CLEAR:     next_rdata = int_latch;  // RULE_06
			ADDR_FALL_MASK_SET,
			ADDR_FALL_MASK_CLEAR:     next_rdata = fall_mask;  // RULE_06
			ADDR_RISE_MASK_SET,
			ADDR_RISE_MASK_CLEAR:     next_rdata = rise_mask;  // RULE_06
			ADDR_CONTROL_THREE_SET,
			ADDR_CONTROL_THREE_CLEAR: next_rdata = control_three;  // RULE_06
			ADDR_PIN_DRIVE_SET,
			ADDR_PIN_DRIVE_CLEAR:     next_rdata = pad_pin(pin_drive);  // RULE_02 RULE_06
			ADDR_PIN_OUTPUT_SET,
			ADDR_PIN_OUTPUT_CLEAR:    next_rdata = pad_pin(gpio_out);  // RULE_02 RULE_06
			ADDR_PIN_INPUT:           next_rdata = pad_pin(pin_level);  // RULE_02
			ADDR_PIN_EVENT_SET,
			ADDR_PIN_EVENT_CLEAR:     next_rdata = pad_pin(pin_event);  // RULE_02 RULE_06
			ADDR_PIN_FALL_SET,
			ADDR_PIN_FALL_CLEAR:      next_rdata = pad_pin(pin_fall_mask);  // RULE_02 RULE_06
			ADDR_PIN_RISE_SET,
			ADDR_PIN_RISE_CLEAR:      next_rdata = pad_pin(pin_rise_mask);  // RULE_02 RULE_06
			default:                  next_rdata = READ_ZERO;  // RULE_03
		endcase
	end

	// registered read answer; data holds until the next read
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rsp.valid <= 1'b0;
			rsp.data  <= READ_ZERO;
		end
		else
		begin
			rsp.valid <= req.rd;
			rsp.data  <= req.rd ? next_rdata : rsp.data;
		end
	end

endmodule : otg_regbank

// *** hdl/otg_pkg.sv ***
// package: register map, reset values and carrier types of the transceiver register bank
package otg_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int GPIO_W = 3;

	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_VENDOR_LOW         = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_VENDOR_HIGH        = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_PRODUCT_LOW        = 8'h02;
	localparam logic [ADDR_W-1:0] ADDR_PRODUCT_HIGH       = 8'h03;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL_ONE_SET    = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL_ONE_CLEAR  = 8'h05;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL_TWO_SET    = 8'h06;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL_TWO_CLEAR  = 8'h07;
	localparam logic [ADDR_W-1:0] ADDR_INT_SOURCE         = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_INT_LATCH_SET      = 8'h0A;
	localparam logic [ADDR_W-1:0] ADDR_INT_LATCH_CLEAR    = 8'h0B;
	localparam logic [ADDR_W-1:0] ADDR_FALL_MASK_SET      = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_FALL_MASK_CLEAR    = 8'h0D;
	localparam logic [ADDR_W-1:0] ADDR_RISE_MASK_SET      = 8'h0E;
	localparam logic [ADDR_W-1:0] ADDR_RISE_MASK_CLEAR    = 8'h0F;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL_THREE_SET  = 8'h12;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL_THREE_CLEAR = 8'h13;
	localparam logic [ADDR_W-1:0] ADDR_PIN_DRIVE_SET      = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_PIN_DRIVE_CLEAR    = 8'h15;
	localparam logic [ADDR_W-1:0] ADDR_PIN_OUTPUT_SET     = 8'h16;
	localparam logic [ADDR_W-1:0] ADDR_PIN_OUTPUT_CLEAR   = 8'h17;
	localparam logic [ADDR_W-1:0] ADDR_PIN_INPUT          = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_PIN_EVENT_SET      = 8'h1A;
	localparam logic [ADDR_W-1:0] ADDR_PIN_EVENT_CLEAR    = 8'h1B;
	localparam logic [ADDR_W-1:0] ADDR_PIN_FALL_SET       = 8'h1C;
	localparam logic [ADDR_W-1:0] ADDR_PIN_FALL_CLEAR     = 8'h1D;
	localparam logic [ADDR_W-1:0] ADDR_PIN_RISE_SET       = 8'h1E;
	localparam logic [ADDR_W-1:0] ADDR_PIN_RISE_CLEAR     = 8'h1F;

	// reset values; bits written as one here come up set
	localparam logic [DATA_W-1:0] RST_CONTROL_ONE   = 8'h00;
	localparam logic [DATA_W-1:0] RST_CONTROL_TWO   = 8'h00;
	localparam logic [DATA_W-1:0] RST_CONTROL_THREE = 8'h00;
	localparam logic [DATA_W-1:0] RST_INT_LATCH     = 8'h00;
	localparam logic [DATA_W-1:0] RST_FALL_MASK     = 8'h00;
	localparam logic [DATA_W-1:0] RST_RISE_MASK     = 8'h00;
	localparam logic [GPIO_W-1:0] RST_PIN_REG       = 3'h0;
	localparam logic [DATA_W-1:0] READ_ZERO         = 8'h00;

	// field positions of named bits; the bank's own logic does not use them
	localparam int CTL2_IDENT_LINE_GROUND   = 4;
	localparam int CTL3_POWER_DOWN_REQUEST  = 0;
	localparam int CTL3_PUMP_DISABLE        = 1;
	localparam int SRC_CARKIT_EVENT         = 7;
	localparam int CTL1_SINGLE_ENDED_SELECT = 2;

	// one access from the serial control engine, valid for one cycle
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} otg_req_s;

	// one read answer
	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] data;
	} otg_rsp_s;

endpackage : otg_pkg

// *** test/otg_regbank_asserts.sv ***
// checker: port assertions of the register bank
`timescale 1ns/1ps
module otg_regbank_asserts #(
	parameter logic [15:0] VENDOR_CODE  = 16'h0000,
	parameter logic [15:0] PRODUCT_CODE = 16'h0000
) (
	input wire logic                       clk,
	input wire logic                       rst,
	input wire otg_pkg::otg_req_s          req,
	input wire otg_pkg::otg_rsp_s          rsp,
	input wire logic [otg_pkg::GPIO_W-1:0] gpio_out,
	input wire logic [otg_pkg::DATA_W-1:0] control_one,
	input wire logic [otg_pkg::DATA_W-1:0] control_two,
	input wire logic [otg_pkg::DATA_W-1:0] control_three,
	input wire logic                       irq
);
	import otg_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	logic gpio_rd;
	logic ro_wr;
	assign gpio_rd = req.rd && (req.addr inside {[8'h14:8'h1F]});
	assign ro_wr = req.wr && ((req.addr inside {[8'h00:8'h03], 8'h08, 8'h09, 8'h10, 8'h11, 8'h18, 8'h19})
		|| req.addr > 8'h1F);
	reset_clears_a: assert property (disable iff (1'b0)
		rst |-> !irq && control_one == RST_CONTROL_ONE && control_two == RST_CONTROL_TWO && control_three == RST_CONTROL_THREE)
		else $error("register not at its reset value during reset");
	read_pulse_a: assert property (
		rsp.valid == $past(req.rd))
		else $error("read answer not one cycle after the read");
	vendor_low_a: assert property (
		req.rd && req.addr == ADDR_VENDOR_LOW |=> rsp.data == VENDOR_CODE[7:0])
		else $error("vendor low byte wrong");
	product_high_a: assert property (
		req.rd && req.addr == ADDR_PRODUCT_HIGH |=> rsp.data == PRODUCT_CODE[15:8])
		else $error("product high byte wrong");
	gpio_upper_a: assert property (
		gpio_rd |=> rsp.data[7:3] == 5'h00)
		else $error("pin register upper bits not zero");
	set_bits_a: assert property (
		req.wr && req.addr == ADDR_CONTROL_ONE_SET |=> control_one == ($past(control_one) | $past(req.wdata)))
		else $error("set write gave wrong contents");
	clear_bits_a: assert property (
		req.wr && req.addr == ADDR_CONTROL_THREE_CLEAR |=> control_three == ($past(control_three) & ~$past(req.wdata)))
		else $error("clear write gave wrong contents");
	pair_read_a: assert property (
		req.rd && req.addr == ADDR_CONTROL_TWO_CLEAR |=> rsp.data == $past(control_two))
		else $error("clear address read differs from contents");
	ro_write_a: assert property (
		ro_wr |=> $stable({control_one, control_two, control_three, gpio_out}))
		else $error("write to read-only place changed state");
endmodule : otg_regbank_asserts
bind otg_regbank otg_regbank_asserts #(.VENDOR_CODE(VENDOR_CODE), .PRODUCT_CODE(PRODUCT_CODE)) u_otg_chk (.clk(clk),
	.rst(rst), .req(req), .rsp(rsp), .gpio_out(gpio_out), .control_one(control_one), .control_two(control_two),
	.control_three(control_three), .irq(irq));

// *** test/otg_host_model.sv ***
// host model: issues one register access at a time and takes its answer
`timescale 1ns/1ps
module otg_host_model (
	input  wire logic              clk,
	output otg_pkg::otg_req_s      req,
	input  wire otg_pkg::otg_rsp_s rsp
);
	import otg_pkg::*;
	initial req = '0;
	// idle address and data are scrambled so nothing leans on stale values
	task automatic xfer(input logic w, input logic r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output otg_rsp_s q);
		@(posedge clk);
		#1 req = '{w, r, a, d};
		@(posedge clk);
		#1 req = '{1'b0, 1'b0, ~a, ~d};
		q = rsp;
	endtask : xfer
endmodule : otg_host_model

// *** test/testbench.sv ***
// testbench: table sweep, event latching, pin drive and reset of the register bank
`timescale 1ns/1ps
module testbench;
	import otg_pkg::*;
	localparam logic [15:0] VC = 16'h6E2B; // arbitrary value
	localparam logic [15:0] PC = 16'h4D19; // arbitrary value
	logic              clk = 1'b0;
	logic              rst = 1'b0;
	logic [DATA_W-1:0] event_source = '0;
	logic [GPIO_W-1:0] gpio_in = '0;
	logic [GPIO_W-1:0] gpio_out;
	logic [GPIO_W-1:0] gpio_oe;
	logic [DATA_W-1:0] control_one;
	logic [DATA_W-1:0] control_two;
	logic [DATA_W-1:0] control_three;
	logic              irq;
	otg_req_s          req;
	otg_rsp_s          rsp;
	otg_rsp_s          q;
	int                failures = 0;
	int                tests_run = 0;
	int                cycles = 0;
	// write address, write data, read address, expected data
	logic [31:0] rows [26] = '{32'h04FF05FF, 32'h050F04F0, 32'h06A507A5, 32'h07210684, 32'h123C133C, 32'h13041238,
		32'h0A810B81, 32'h0B810A00, 32'h0C420D42, 32'h0E800F80, 32'h14FF1507, 32'h17FF1600, 32'h1E051F05,
		32'h1C021D02, 32'h1AFF1B07, 32'h1B071A00, 32'h00FF002B, 32'h01FF016E, 32'h03FF0219, 32'h08FF034D,
		32'h19FF04F0, 32'h10FF0684, 32'h20FF1338, 32'h09FF0900, 32'h18FF1800, 32'h11FF0800};
	always #5 clk = ~clk;
	otg_regbank #(.VENDOR_CODE(VC), .PRODUCT_CODE(PC)) u_otg_regbank (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
		.event_source(event_source), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.control_one(control_one), .control_two(control_two), .control_three(control_three), .irq(irq));
	otg_host_model u_otg_host_model (.clk(clk), .req(req), .rsp(rsp));
	task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		u_otg_host_model.xfer(1'b0, 1'b1, a, 8'h00, q);
		chk("read valid", 8'h01, {7'h00, q.valid});
		chk("read data", e, q.data);
	endtask : rd
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		u_otg_host_model.xfer(1'b1, 1'b0, a, d, q);
	endtask : wr
	task automatic close_out;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			close_out();
		end
	end
	initial
	begin
		// a real rising edge of reset, so the bank is cleared before the first clock
		#1 rst = 1'b1;
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		foreach (rows[i])
		begin
			wr(rows[i][31:24], rows[i][23:16]);
			rd(rows[i][15:8], rows[i][7:0]);
		end
		chk("control two port", 8'h84, control_two);
		chk("control three port", 8'h38, control_three);
		// write and read in one cycle: read sees the old contents
		u_otg_host_model.xfer(1'b1, 1'b1, ADDR_CONTROL_ONE_SET, 8'h0F, q);
		chk("same cycle read", 8'hF0, q.data);
		rd(ADDR_CONTROL_ONE_CLEAR, 8'hFF);
		event_source = 8'h80;
		repeat (2) @(posedge clk);
		#1 chk("irq on rise", 8'h01, {7'h00, irq});
		rd(ADDR_INT_LATCH_SET, 8'h80);
		rd(ADDR_INT_SOURCE, 8'h80);
		wr(ADDR_INT_LATCH_CLEAR, 8'h80);
		event_source = 8'h00;
		rd(ADDR_INT_LATCH_CLEAR, 8'h00);
		chk("irq cleared", 8'h00, {7'h00, irq});
		// a masked fall and a clear of the same bit in one cycle: the edge wins
		event_source = 8'h40;
		fork
			wr(ADDR_INT_LATCH_CLEAR, 8'h40);
			begin
				@(posedge clk);
				#1 event_source = 8'h00;
			end
		join
		rd(ADDR_INT_LATCH_SET, 8'h40);
		wr(ADDR_INT_LATCH_CLEAR, 8'h40);
		rd(ADDR_INT_LATCH_CLEAR, 8'h00);
		gpio_in = 3'h5;
		repeat (3) @(posedge clk);
		#1 chk("irq on pin", 8'h01, {7'h00, irq});
		rd(ADDR_PIN_EVENT_SET, 8'h05);
		rd(ADDR_PIN_INPUT, 8'h05);
		chk("pin pull", 8'h07, {5'h00, gpio_oe});
		wr(ADDR_PIN_OUTPUT_SET, 8'h03);
		@(posedge clk);
		#1 chk("pin out", 8'h03, {5'h00, gpio_out});
		chk("pin pull", 8'h04, {5'h00, gpio_oe});
		gpio_in = 3'h0;
		rst = 1'b1;
		@(posedge clk);
		#1 chk("reset ctl", RST_CONTROL_ONE, control_one);
		chk("reset pull", 8'h00, {5'h00, gpio_oe});
		chk("reset irq", 8'h00, {7'h00, irq});
		chk("reset ctl two", RST_CONTROL_TWO, control_two);
		chk("reset ctl three", RST_CONTROL_THREE, control_three);
		rst = 1'b0;
		rd(ADDR_CONTROL_ONE_CLEAR, RST_CONTROL_ONE);
		rd(ADDR_PIN_DRIVE_CLEAR, 8'h00);
		rd(ADDR_VENDOR_HIGH, VC[15:8]);
		close_out();
	end
endmodule : testbench
